/* File: src/gpio_port_controller.sv */
// Purpose: three-port general purpose i/o with edge flags and dma requests
// Assumes: sleep_mode, periph_* and audio_serial_enable are on mclk
// Notes:   pins pass two flops before use; one wait state per bus access
`timescale 1ns/1ns
`default_nettype none

module gpio_port_controller (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output var  logic [31:0] readdata,
  output var  logic        waitrequest,
  input  wire logic [20:0] pin_in,
  output var  logic [20:0] pin_out,
  output var  logic [20:0] pin_oe,
  output var  logic [20:0] pull_up,
  output var  logic [20:0] pull_down,
  input  wire logic [20:0] periph_out,
  input  wire logic [20:0] periph_oe,
  input  wire logic        audio_serial_enable,
  input  wire logic [1:0]  sleep_mode,
  output var  logic [2:0]  port_irq,
  output var  logic        wake,
  output var  logic        rising_edge_dma_request,
  output var  logic        falling_edge_dma_request
);

  // **********************************************
  // helpers for moving a port byte in and out
  // **********************************************
  function automatic logic [20:0] put_byte(input logic [20:0] old, input logic [1:0] port,
                                           input logic [7:0] d);
    logic [20:0] v;
    v = old;
    if (port == gpio_port_pkg::PORT0) begin
      v[gpio_port_pkg::P0_LSB +: gpio_port_pkg::PWIDTH] = d;
    end else if (port == gpio_port_pkg::PORT1) begin
      v[gpio_port_pkg::P1_LSB +: gpio_port_pkg::PWIDTH] = d;
    end else if (port == gpio_port_pkg::PORT2) begin
      v[gpio_port_pkg::P2_LSB +: gpio_port_pkg::P2WIDTH] = d[gpio_port_pkg::P2WIDTH-1:0];
    end
    return v;
  endfunction : put_byte

  function automatic logic [7:0] get_byte(input logic [20:0] v, input logic [1:0] port);
    logic [7:0] b;
    b = 8'h00;
    if (port == gpio_port_pkg::PORT0) begin
      b = v[gpio_port_pkg::P0_LSB +: gpio_port_pkg::PWIDTH];
    end else if (port == gpio_port_pkg::PORT1) begin
      b = v[gpio_port_pkg::P1_LSB +: gpio_port_pkg::PWIDTH];
    end else if (port == gpio_port_pkg::PORT2) begin
      b[gpio_port_pkg::P2WIDTH-1:0] = v[gpio_port_pkg::P2_LSB +: gpio_port_pkg::P2WIDTH];
    end
    return b;
  endfunction : get_byte

  // **********************************************
  // state
  // **********************************************
  gpio_port_pkg::pin_cfg_t cfg_r;
  gpio_port_pkg::pin_cfg_t cfg_nxt;
  logic [20:0] latch_r;
  logic [20:0] latch_nxt;
  logic [20:0] flag_r;
  logic [20:0] flag_nxt;
  logic [7:0]  port1_bit_irq_enables_r;
  logic [5:0]  port_irq_control_r;
  logic [2:0]  pulldn_r;
  logic [2:0]  cpu_en_r;
  logic [2:0]  cpu_flag_r;
  logic [2:0]  cpu_flag_nxt;
  logic [20:0] sync1_r;
  logic [20:0] sync2_r;
  logic [20:0] sync3_r;
  logic [2:0]  prime_r;

  // **********************************************
  // bus decode
  // **********************************************
  wire        req      = read | write;
  wire        wr_ok    = write & ~waitrequest & byteenable[0];
  wire [3:0]  grp      = address[7:4];
  wire [1:0]  port     = address[3:2];
  wire        port_ok  = (port != 2'h3) & (address[1:0] == 2'h0);
  wire [7:0]  wd       = writedata[7:0];
  wire        wr_data  = wr_ok & port_ok & (grp == gpio_port_pkg::GRP_DATA);
  wire        wr_sel   = wr_ok & port_ok & (grp == gpio_port_pkg::GRP_SEL);
  wire        wr_dir   = wr_ok & port_ok & (grp == gpio_port_pkg::GRP_DIR);
  wire        wr_inp   = wr_ok & port_ok & (grp == gpio_port_pkg::GRP_INP);
  wire        wr_flag  = wr_ok & port_ok & (grp == gpio_port_pkg::GRP_FLAG);
  wire        wr_port1_bit_irq_enables = wr_ok & (address == gpio_port_pkg::OFS_PORT1_BIT_IRQ_ENABLES);
  wire        wr_port_irq_control = wr_ok & (address == gpio_port_pkg::OFS_PORT_IRQ_CONTROL);
  wire        wr_pdn   = wr_ok & (address == gpio_port_pkg::OFS_PULLDN);
  wire        wr_cen   = wr_ok & (address == gpio_port_pkg::OFS_CPUEN);
  wire        wr_cflg  = wr_ok & (address == gpio_port_pkg::OFS_CPUFLG);
  wire        wr_bop   = wr_ok & (address == gpio_port_pkg::OFS_BITOP);

  // bit operation target: port*8+bit lands on the packed pin index
  wire [1:0]  bop_port = wd[gpio_port_pkg::BOP_PORT_LSB +: 2];
  wire [2:0]  bop_bit  = wd[gpio_port_pkg::BOP_BIT_LSB +: 3];
  wire [1:0]  bop_op   = wd[gpio_port_pkg::BOP_OP_LSB +: 2];
  wire [4:0]  bop_idx  = {bop_port, bop_bit};
  wire        bop_ok   = (bop_port == gpio_port_pkg::PORT0) | (bop_port == gpio_port_pkg::PORT1)
                       | ((bop_port == gpio_port_pkg::PORT2) & (bop_bit <= gpio_port_pkg::P2_TOPBIT));
  wire        bop_old  = latch_r[bop_idx];
  wire        bop_new  = (bop_op == gpio_port_pkg::BOP_SET) ? 1'b1 :
                         (bop_op == gpio_port_pkg::BOP_TGL) ? ~bop_old :
                         (bop_op == gpio_port_pkg::BOP_CLR) ? 1'b0 : bop_old;

  // flag clear masks: zero written clears, one keeps
  wire [20:0] flag_clr = wr_flag ? ~put_byte(21'h1fffff, port, wd) : 21'h000000;
  wire [2:0]  cpu_clr  = wr_cflg ? ~wd[2:0] : 3'h0;

  // **********************************************
  // edge detection and interrupt conditions
  // **********************************************
  wire [20:0] gp_in   = ~cfg_r.sel & ~cfg_r.dir;
  // sync flops wake up at zero, so a pulled-high pin would look like a rising edge
  wire        primed  = prime_r[2];
  wire [20:0] rise    = sync2_r & ~sync3_r & {gpio_port_pkg::NPIN{primed}};
  wire [20:0] fall    = ~sync2_r & sync3_r & {gpio_port_pkg::NPIN{primed}};
  wire [20:0] pol     = {{gpio_port_pkg::P2WIDTH{port_irq_control_r[gpio_port_pkg::PORT_IRQ_CONTROL_POL2]}},
                         {gpio_port_pkg::PWIDTH{port_irq_control_r[gpio_port_pkg::PORT_IRQ_CONTROL_POL1]}},
                         {gpio_port_pkg::PWIDTH{port_irq_control_r[gpio_port_pkg::PORT_IRQ_CONTROL_POL0]}}};
  wire [20:0] cond    = gp_in & ((pol & fall) | (~pol & rise));
  wire [7:0]  p0_en   = {{4{port_irq_control_r[gpio_port_pkg::PORT_IRQ_CONTROL_P0H]}}, {4{port_irq_control_r[gpio_port_pkg::PORT_IRQ_CONTROL_P0L]}}};
  wire [4:0]  p2_en   = {gpio_port_pkg::P2WIDTH{port_irq_control_r[gpio_port_pkg::PORT_IRQ_CONTROL_P2EN]}};
  wire [2:0]  sub_hit = {|(cond[gpio_port_pkg::P2_LSB +: gpio_port_pkg::P2WIDTH] & p2_en),
                         |(cond[gpio_port_pkg::P1_LSB +: gpio_port_pkg::PWIDTH] & port1_bit_irq_enables_r),
                         |(cond[gpio_port_pkg::P0_LSB +: gpio_port_pkg::PWIDTH] & p0_en)};
  wire        awake   = (sleep_mode == gpio_port_pkg::SLEEP_ACTIVE);

  // **********************************************
  // next-state logic
  // **********************************************
  always_comb begin
    latch_nxt = latch_r;
    if (wr_data) begin
      latch_nxt = put_byte(latch_r, port, wd);
    end else if (wr_bop & bop_ok) begin
      latch_nxt[bop_idx] = bop_new;
    end
  end

  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_sel) begin
      cfg_nxt.sel = put_byte(cfg_r.sel, port, wd);
    end
    if (wr_dir) begin
      cfg_nxt.dir = put_byte(cfg_r.dir, port, wd);
    end
    if (wr_inp) begin
      cfg_nxt.inp = put_byte(cfg_r.inp, port, wd);
    end
  end

  // a new edge beats a clearing write in the same cycle
  assign flag_nxt     = (flag_r & ~flag_clr) | cond;
  assign cpu_flag_nxt = (cpu_flag_r & ~cpu_clr) | (sub_hit & {3{awake}});

  // **********************************************
  // pin drive and pulls
  // **********************************************
  wire [20:0] audio_own  = audio_serial_enable ? gpio_port_pkg::AUDIO_PIN_MASK : gpio_port_pkg::RST_ZERO;
  wire [20:0] periph_own = cfg_r.sel | audio_own;
  wire [20:0] drv_out    = (periph_own & periph_out) | (~periph_own & latch_r);
  wire [20:0] drv_oe     = (periph_own & periph_oe) | (~periph_own & cfg_r.dir);
  wire [20:0] pdn_sel    = {{gpio_port_pkg::P2WIDTH{pulldn_r[2]}},
                            {gpio_port_pkg::PWIDTH{pulldn_r[1]}},
                            {gpio_port_pkg::PWIDTH{pulldn_r[0]}}};
  wire [20:0] pulled     = ~drv_oe & ~cfg_r.inp & ~gpio_port_pkg::NO_PULL_MASK;

  // drive frozen while any low-power mode is active
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_out   <= gpio_port_pkg::RST_ZERO;
      pin_oe    <= gpio_port_pkg::RST_ZERO;
      pull_up   <= gpio_port_pkg::RST_PULLUP;
      pull_down <= gpio_port_pkg::RST_ZERO;
    end else if (awake) begin
      pin_out   <= drv_out;
      pin_oe    <= drv_oe;
      pull_up   <= pulled & ~pdn_sel;
      pull_down <= pulled & pdn_sel;
    end
  end

  // **********************************************
  // registers
  // **********************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg_r   <= '0;
      latch_r <= gpio_port_pkg::RST_ZERO;
      flag_r  <= gpio_port_pkg::RST_ZERO;
    end else begin
      cfg_r   <= cfg_nxt;
      latch_r <= latch_nxt;
      flag_r  <= flag_nxt;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      port1_bit_irq_enables_r  <= 8'h00;
      port_irq_control_r  <= 6'h00;
      pulldn_r <= 3'h0;
      cpu_en_r <= 3'h0;
    end else begin
      if (wr_port1_bit_irq_enables) port1_bit_irq_enables_r  <= wd;
      if (wr_port_irq_control) port_irq_control_r  <= wd[5:0];
      if (wr_pdn)   pulldn_r <= wd[2:0];
      if (wr_cen)   cpu_en_r <= wd[2:0];
    end
  end

  // only sync2 reads sync1; edge logic looks at sync2/sync3
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= gpio_port_pkg::RST_ZERO;
      sync2_r <= gpio_port_pkg::RST_ZERO;
      sync3_r <= gpio_port_pkg::RST_ZERO;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // startup guard: edges count only once sync3 holds a real pin sample
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prime_r <= 3'h0;
    end else begin
      prime_r <= {prime_r[1:0], 1'b1};
    end
  end

  // **********************************************
  // interrupts, wake and dma
  // **********************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cpu_flag_r               <= 3'h0;
      port_irq                 <= 3'h0;
      wake                     <= 1'b0;
      rising_edge_dma_request  <= 1'b0;
      falling_edge_dma_request <= 1'b0;
    end else begin
      cpu_flag_r               <= cpu_flag_nxt;
      port_irq                 <= cpu_flag_nxt & cpu_en_r;
      // wake ignores the sleep block so edges still rouse the core
      wake                     <= |(sub_hit & cpu_en_r);
      rising_edge_dma_request  <= rise[gpio_port_pkg::DMA_RISE_PIN] & gp_in[gpio_port_pkg::DMA_RISE_PIN];
      falling_edge_dma_request <= fall[gpio_port_pkg::DMA_FALL_PIN] & gp_in[gpio_port_pkg::DMA_FALL_PIN];
    end
  end

  // **********************************************
  // avalon read data and wait state
  // **********************************************
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    if (port_ok & (grp == gpio_port_pkg::GRP_DATA)) begin
      rd_byte = get_byte(sync2_r, port);
    end else if (port_ok & (grp == gpio_port_pkg::GRP_SEL)) begin
      rd_byte = get_byte(cfg_r.sel, port);
    end else if (port_ok & (grp == gpio_port_pkg::GRP_DIR)) begin
      rd_byte = get_byte(cfg_r.dir, port);
    end else if (port_ok & (grp == gpio_port_pkg::GRP_INP)) begin
      rd_byte = get_byte(cfg_r.inp, port);
    end else if (port_ok & (grp == gpio_port_pkg::GRP_FLAG)) begin
      rd_byte = get_byte(flag_r, port);
    end else if (address == gpio_port_pkg::OFS_PORT1_BIT_IRQ_ENABLES) begin
      rd_byte = port1_bit_irq_enables_r;
    end else if (address == gpio_port_pkg::OFS_PORT_IRQ_CONTROL) begin
      rd_byte = {2'h0, port_irq_control_r};
    end else if (address == gpio_port_pkg::OFS_PULLDN) begin
      rd_byte = {5'h00, pulldn_r};
    end else if (address == gpio_port_pkg::OFS_CPUEN) begin
      rd_byte = {5'h00, cpu_en_r};
    end else if (address == gpio_port_pkg::OFS_CPUFLG) begin
      rd_byte = {5'h00, cpu_flag_r};
    end
  end

  // one wait state: data captured while waitrequest is high, held at release edge
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
    end else begin
      waitrequest <= ~(req & waitrequest);
      if (read & waitrequest) readdata <= {24'h000000, rd_byte};
    end
  end

endmodule : gpio_port_controller

`default_nettype wire

/* File: src/gpio_port_pkg.sv */
// Purpose: shared constants and types of the gpio port controller
// Assumes: 21 pins packed as port0 [7:0], port1 [15:8], port2 [20:16]
// Notes:   byte addresses on a 32-bit avalon-mm slave, data in the low byte
package gpio_port_pkg;

  localparam int          NPIN      = 21;
  localparam int          PWIDTH    = 8;
  localparam int          P2WIDTH   = 5;
  localparam int          P0_LSB    = 0;
  localparam int          P1_LSB    = 8;
  localparam int          P2_LSB    = 16;
  localparam logic [1:0]  PORT0     = 2'h0;
  localparam logic [1:0]  PORT1     = 2'h1;
  localparam logic [1:0]  PORT2     = 2'h2;
  localparam logic [2:0]  P2_TOPBIT = 3'h4;

  // **********************************************
  // address map: port groups sit 16 bytes apart
  // **********************************************
  localparam logic [3:0]  GRP_DATA   = 4'h0;
  localparam logic [3:0]  GRP_SEL    = 4'h1;
  localparam logic [3:0]  GRP_DIR    = 4'h2;
  localparam logic [3:0]  GRP_INP    = 4'h3;
  localparam logic [3:0]  GRP_FLAG   = 4'h4;
  localparam logic [7:0]  OFS_PORT1_BIT_IRQ_ENABLES  = 8'h50;
  localparam logic [7:0]  OFS_PORT_IRQ_CONTROL  = 8'h54;
  localparam logic [7:0]  OFS_PULLDN = 8'h58;
  localparam logic [7:0]  OFS_CPUEN  = 8'h5c;
  localparam logic [7:0]  OFS_CPUFLG = 8'h60;
  localparam logic [7:0]  OFS_BITOP  = 8'h64;

  // port_irq_control fields
  localparam int          PORT_IRQ_CONTROL_POL0 = 0;
  localparam int          PORT_IRQ_CONTROL_POL1 = 1;
  localparam int          PORT_IRQ_CONTROL_POL2 = 2;
  localparam int          PORT_IRQ_CONTROL_P0L  = 3;
  localparam int          PORT_IRQ_CONTROL_P0H  = 4;
  localparam int          PORT_IRQ_CONTROL_P2EN = 5;

  // bit operation register fields and codes
  localparam int          BOP_PORT_LSB = 0;
  localparam int          BOP_BIT_LSB  = 2;
  localparam int          BOP_OP_LSB   = 5;
  localparam logic [1:0]  BOP_CLR      = 2'h0;
  localparam logic [1:0]  BOP_SET      = 2'h1;
  localparam logic [1:0]  BOP_TGL      = 2'h2;

  // **********************************************
  // reset values and fixed pin masks
  // **********************************************
  localparam logic [20:0] RST_ZERO       = 21'h000000;
  localparam logic [20:0] RST_PULLUP     = 21'h040000;
  localparam logic [20:0] NO_PULL_MASK   = 21'h000300;
  localparam logic [20:0] AUDIO_PIN_MASK = 21'h0f0000;
  localparam int          DMA_RISE_PIN   = 1;
  localparam int          DMA_FALL_PIN   = 11;
  localparam logic [1:0]  SLEEP_ACTIVE   = 2'h0;

  typedef struct packed {
    logic [20:0] sel;
    logic [20:0] dir;
    logic [20:0] inp;
  } pin_cfg_t;

endpackage : gpio_port_pkg

/* File: sim/gpio_port_sva.sv */
// Purpose: port-level assertions for the gpio port controller
// Assumes: the bench never changes cpu enables while asleep
// Notes:   pin events reach the outputs within four edges
`timescale 1ns/1ns
`default_nettype none
module gpio_port_sva (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic [20:0] pin_in,
  input wire logic [20:0] pin_out,
  input wire logic [20:0] pin_oe,
  input wire logic [20:0] pull_up,
  input wire logic [20:0] pull_down,
  input wire logic [20:0] periph_out,
  input wire logic [20:0] periph_oe,
  input wire logic        audio_serial_enable,
  input wire logic [1:0]  sleep_mode,
  input wire logic [2:0]  port_irq,
  input wire logic        wake,
  input wire logic        rising_edge_dma_request,
  input wire logic        falling_edge_dma_request
);
  // ****************************
  // bus, pull, event and sleep checks
  // ****************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  chk_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("access not answered after one wait state");
  chk_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_upper_zero: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_reset_pull: assert property ($rose(resetn) |-> pull_up == gpio_port_pkg::RST_PULLUP)
    else $error("pull-up during reset not limited to one pin");
  chk_no_pull: assert property (((pull_up | pull_down) & gpio_port_pkg::NO_PULL_MASK) == 21'h0)
    else $error("pull applied on a pin without pull");
  chk_dma_rise: assert property (rising_edge_dma_request |-> !pin_oe[1] && $past(pin_in[1]) && !$past(pin_in[1], 5))
    else $error("rising dma request without rising input edge");
  chk_dma_fall: assert property (falling_edge_dma_request |-> !pin_oe[11] && !$past(pin_in[11]) && $past(pin_in[11], 5))
    else $error("falling dma request without falling input edge");
  chk_dma_single: assert property (rising_edge_dma_request |=> !rising_edge_dma_request)
    else $error("dma request longer than one cycle");
  chk_irq_awake: assert property ($rose(|port_irq) |-> $past(sleep_mode) == 2'h0)
    else $error("port interrupt raised while asleep");
  chk_pins_frozen: assert property (sleep_mode != 2'h0 && $past(sleep_mode) != 2'h0
    |-> $stable(pin_out) && $stable(pin_oe) && $stable(pull_up))
    else $error("pin state changed in low-power mode");
  cov_rise: cover property (rising_edge_dma_request);
  cov_fall: cover property (falling_edge_dma_request);
  cov_irq: cover property ($rose(port_irq[1]));
  cov_wake: cover property (wake && sleep_mode != 2'h0);
endmodule : gpio_port_sva
bind gpio_port_controller gpio_port_sva chk_u (.*);
`default_nettype wire

/* File: sim/pin_env.sv */
// Purpose: external circuit on the gpio pins
// Assumes: device drive wins over the bench drive
// Notes:   an undriven, unpulled pin wanders every cycle
`timescale 1ns/1ns
`default_nettype none
module pin_env (
  input  wire logic        mclk,
  input  wire logic [20:0] pin_out,
  input  wire logic [20:0] pin_oe,
  input  wire logic [20:0] pull_up,
  input  wire logic [20:0] pull_down,
  input  wire logic [20:0] ext_val,
  input  wire logic [20:0] ext_oe,
  output var  logic [20:0] pin_in
);
  logic [20:0] float_r = 21'h0a5a5;
  // a floating wire offers no stable value to lean on
  always_ff @(posedge mclk) float_r <= ~float_r;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
                | (~pin_oe & ~ext_oe & (pull_up | (~pull_down & float_r)));
endmodule : pin_env
`default_nettype wire

/* File: sim/test_gpio_port_controller.sv */
// Purpose: self-checking bench of the gpio port controller
// Assumes: one wait state per access, pins settle within six edges
// Notes:   random pin levels and bit numbers from a fixed seed
`timescale 1ns/1ns
`default_nettype none
module test_gpio_port_controller;
  logic        mclk = 1'b0, resetn = 1'b0, read = 1'b0, write = 1'b0;
  logic [7:0]  address = 8'h00, q, v, lat;
  logic [31:0] writedata = 32'h0, readdata;
  logic [3:0]  byteenable = 4'hf;
  logic        waitrequest, wake, rising_edge_dma_request, falling_edge_dma_request;
  logic [20:0] pin_in, pin_out, pin_oe, pull_up, pull_down, ext_val = 21'h0;
  logic [20:0] periph_out = 21'h0, periph_oe = 21'h0, ext_oe = 21'h1fffff;
  logic        audio_serial_enable = 1'b0;
  logic [1:0]  sleep_mode = 2'h0;
  logic [2:0]  port_irq;
  int          mismatches = 0, n_tests = 0, n_rise = 0, n_fall = 0, n_wake = 0, r, f;
  gpio_port_controller dut_u (.*);
  pin_env env_u (.*);
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (rising_edge_dma_request === 1'b1) n_rise++;
    if (falling_edge_dma_request === 1'b1) n_fall++;
    if (wake === 1'b1) n_wake++;
  end
  // ****************************
  // expectations, bus and pin tasks
  // ****************************
  function automatic logic [7:0] bitop(logic [7:0] l, logic [2:0] b, logic [1:0] op);
    if (op == gpio_port_pkg::BOP_CLR) return l & ~(8'h01 << b);
    if (op == gpio_port_pkg::BOP_SET) return l | (8'h01 << b);
    return l ^ (8'h01 << b);
  endfunction : bitop
  function automatic logic [7:0] port_bits(logic [20:0] x, int p);
    return (p == 2) ? {3'h0, x[20:16]} : x[p*8 +: 8];
  endfunction : port_bits
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic bus(input logic wr_en, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge mclk);
    address <= a;
    writedata <= {24'h0, d};
    write <= wr_en;
    read <= !wr_en;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    if (n >= 40) mismatches++;
    q = readdata[7:0];
    check(readdata[31:8], 24'h0);
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(q, exp);
  endtask : rd
  task automatic pins(input logic [20:0] x);
    @(posedge mclk);
    ext_val <= x;
    repeat (6) @(posedge mclk);
  endtask : pins
  task automatic complete_run;
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    #200000;
    mismatches++;
    complete_run();
  end
  // ****************************
  // main sequence
  // ****************************
  initial begin
    void'($urandom(85130));
    repeat (10) @(posedge mclk);
    check(pull_up, gpio_port_pkg::RST_PULLUP);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    check(pull_up, 21'h1fffff & ~gpio_port_pkg::NO_PULL_MASK);
    for (int p = 0; p < 3; p++) begin
      rd(8'h10 + 8'(4 * p), 8'h00);
      rd(8'h20 + 8'(4 * p), 8'h00);
    end
    rd(8'h7c, 8'h00);
    byteenable <= 4'h0;
    wr(8'h20, 8'hff);
    byteenable <= 4'hf;
    rd(8'h20, 8'h00);
    repeat (4) begin
      pins(21'($urandom()));
      for (int p = 0; p < 3; p++) rd(8'(4 * p), port_bits(ext_val, p));
    end
    pins(21'h0);
    v = 8'($urandom());
    wr(8'h20, 8'hff);
    wr(8'h00, v);
    wr(8'h28, 8'hff);
    wr(8'h08, 8'hff);
    repeat (2) @(posedge mclk);
    check(pin_oe, 21'h1f00ff);
    check({pin_out[20:16], pin_out[7:0]}, {5'h1f, v});
    periph_oe <= 21'h0f0001;
    periph_out <= {20'h28000, ~v[0]};
    wr(8'h10, 8'h01);
    pins(21'h0);
    check({pin_oe[19:16], pin_oe[0], pin_out[19:16], pin_out[0]}, {4'hf, 1'b1, 4'hf, ~v[0]});
    audio_serial_enable <= 1'b1;
    pins(21'h0);
    check({pin_oe[19:16], pin_out[19:16]}, 8'hf5);
    audio_serial_enable <= 1'b0;
    wr(8'h10, 8'h00);
    wr(8'h20, 8'h00);
    wr(8'h28, 8'h00);
    wr(8'h34, 8'h0f);
    repeat (2) @(posedge mclk);
    check(pull_up[15:8], 8'hf0);
    wr(8'h58, 8'h02);
    repeat (2) @(posedge mclk);
    check({pull_up[15:8], pull_down[15:8]}, 16'h00f0);
    wr(8'h58, 8'h00);
    wr(8'h34, 8'h00);
    lat = 8'ha5;
    wr(8'h04, lat);
    pins(21'h005a00);
    for (int op = 0; op < 3; op++) begin
      r = $urandom_range(7);
      lat = bitop(lat, 3'(r), 2'(op));
      wr(8'h64, {1'b0, 2'(op), 3'(r), 2'h1});
      pins(ext_val);
      check(pin_out[15:8], lat);
    end
    pins(21'h0);
    for (int p = 0; p < 3; p++) wr(8'h40 + 8'(4 * p), 8'h00);
    v = 8'($urandom()) | 8'h81;
    pins({5'h0, v, 8'h00});
    rd(8'h44, v);
    rd(8'h60, 8'h00);
    wr(8'h44, 8'hff);
    rd(8'h44, v);
    wr(8'h44, 8'h0f);
    rd(8'h44, v & 8'h0f);
    wr(8'h44, 8'h00);
    wr(8'h54, 8'h02);
    pins(21'h0);
    rd(8'h44, v);
    wr(8'h54, 8'h08);
    wr(8'h5c, 8'h01);
    pins(21'h0000f0);
    rd(8'h60, 8'h00);
    pins(21'h0000f1);
    rd(8'h60, 8'h01);
    check(port_irq, 3'h1);
    wr(8'h40, 8'h00);
    wr(8'h60, 8'h00);
    pins(ext_val);
    check(port_irq, 3'h0);
    wr(8'h54, 8'h00);
    wr(8'h50, 8'hff);
    wr(8'h5c, 8'h02);
    wr(8'h44, 8'h00);
    sleep_mode <= 2'h1;
    r = n_wake;
    pins(21'h00fff1);
    rd(8'h44, 8'hff);
    rd(8'h60, 8'h00);
    check(n_wake != r, 1);
    wr(8'h04, 8'h3c);
    pins(ext_val);
    check(pin_out[15:8], lat);
    sleep_mode <= 2'h0;
    pins(21'h0000f1);
    wr(8'h44, 8'h00);
    pins(21'h00fff1);
    rd(8'h60, 8'h02);
    check(port_irq, 3'h2);
    wr(8'h44, 8'h00);
    wr(8'h60, 8'h00);
    r = n_rise;
    f = n_fall;
    pins(21'h00fff3);
    pins(21'h00f7f3);
    check(n_rise - r, 32'h1);
    check(n_fall - f, 32'h1);
    wr(8'h20, 8'h02);
    wr(8'h24, 8'h08);
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h08);
    pins(ext_val);
    wr(8'h00, 8'h02);
    wr(8'h04, 8'h00);
    wr(8'h20, 8'h00);
    wr(8'h10, 8'h02);
    pins(21'h00f7f1);
    pins(21'h00f7f3);
    check(n_rise - r, 32'h1);
    check(n_fall - f, 32'h1);
    // port2: single enable, falling polarity, own cpu enable
    wr(8'h48, 8'h00);
    wr(8'h54, 8'h24);
    wr(8'h5c, 8'h04);
    pins(21'h10f7f3);
    rd(8'h48, 8'h00);
    pins(21'h00f7f3);
    rd(8'h48, 8'h10);
    rd(8'h60, 8'h04);
    check(port_irq, 3'h4);
    complete_run();
  end
endmodule : test_gpio_port_controller
`default_nettype wire
